// file: common/accr_pkg.sv
package accr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus widths
    localparam int ACCR_ADDR_W = 6;
    localparam int ACCR_DATA_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [5:0] ACCR_CH1_OCAL_LOW_OFS  = 6'h10;
    localparam logic [5:0] ACCR_CH1_GAIN_HIGH_OFS = 6'h11;
    localparam logic [5:0] ACCR_CH1_GAIN_LOW_OFS  = 6'h12;
    localparam logic [5:0] ACCR_CH2_INPUT_CONFIG_OFS       = 6'h13;
    localparam logic [5:0] ACCR_CH2_OFS_HIGH_OFS  = 6'h14;
    localparam logic [5:0] ACCR_CH2_OFS_LOW_OFS   = 6'h15;
    localparam logic [5:0] ACCR_CH2_GAIN_HIGH_OFS = 6'h16;
    localparam logic [5:0] ACCR_CH2_GAIN_LOW_OFS  = 6'h17;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] ACCR_GAIN_HIGH_RST = 16'h8000;
    localparam logic [15:0] ACCR_ZERO_RST      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int ACCR_LOW_BYTE_LSB  = 8;
    localparam int ACCR_PHASE_LSB     = 6;
    localparam int ACCR_TEMP_SENSOR_SOURCE_SELECT_BIT    = 5;
    localparam int ACCR_TEMP_SENSOR_MEASURE_ENABLE_BIT     = 4;
    localparam int ACCR_TS_INV_BIT    = 2;
    localparam int ACCR_MUX_LSB       = 0;
    localparam logic [15:0] ACCR_CFG_WMASK = 16'hfff7;

    ////////////////////////////////////////////////////////////////////////
    // input selector codes
    typedef enum logic [1:0] {
        ACCR_IN_NORMAL  = 2'b00,
        ACCR_IN_SHORTED = 2'b01,
        ACCR_IN_DC_DIAG = 2'b10,
        ACCR_IN_AC_DIAG = 2'b11
    } accr_input_sel_type;

    // outputs toward the correction path of one channel
    typedef struct packed {
        logic signed [23:0] offset_word;
        logic        [23:0] gain_word;
    } accr_cal_type;

    typedef struct packed {
        logic signed [9:0]  ch2_phase_delay;
        accr_input_sel_type ch2_input_select;
        logic               temp_sensor_source_select;
        logic               temp_sensor_measure_enable;
        logic               temp_sensor_polarity_invert;
    } accr_ch2_input_config_type;

endpackage

// file: dv/accr_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
module accr_regs_props
    import accr_pkg::*;
(
    // clock and reset
    input wire logic             CLOCK_I,
    input wire logic             RST_I,
    // register port
    input wire logic [5:0]       ADDR_I,
    input wire logic [15:0]      WDATA_I,
    input wire logic             WR_I,
    input wire logic             RD_I,
    input wire logic [15:0]      RDATA_O,
    // datapath side
    input wire accr_cal_type     CH1_CAL_O,
    input wire accr_cal_type     CH2_CAL_O,
    input wire accr_ch2_input_config_type CH2_INPUT_CONFIG_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    gain_high_wr_a: assert property (WR_I && ADDR_I == 6'h11 |=>
        CH1_CAL_O.gain_word[23:8] == $past(WDATA_I)) else $error("gain high");
    gain_low_wr_a: assert property (WR_I && ADDR_I == 6'h17 |=>
        CH2_CAL_O.gain_word[7:0] == $past(WDATA_I[15:8])) else $error("gain lo");
    ofs_high_wr_a: assert property (WR_I && ADDR_I == 6'h14 |=>
        CH2_CAL_O.offset_word[23:8] == $past(WDATA_I)) else $error("ofs high");
    ofs_low_wr_a: assert property (WR_I && ADDR_I == 6'h15 |=>
        CH2_CAL_O.offset_word[7:0] == $past(WDATA_I[15:8])) else $error("ofs lo");
    low_byte_zero_a: assert property (RD_I &&
        ADDR_I inside {6'h10, 6'h12, 6'h15, 6'h17} |=> RDATA_O[7:0] == 8'h00)
        else $error("low byte not zero");
    cfg_write_a: assert property (WR_I && ADDR_I == 6'h13 |=>
        CH2_INPUT_CONFIG_O == {$past(WDATA_I[15:6]), $past(WDATA_I[1:0]),
        $past(WDATA_I[5]), $past(WDATA_I[4]), $past(WDATA_I[2])})
        else $error("cfg write");
    cfg_hold_a: assert property (!(WR_I && ADDR_I == 6'h13) |=>
        $stable(CH2_INPUT_CONFIG_O)) else $error("cfg moved");
    cfg_rsvd_a: assert property (RD_I && ADDR_I == 6'h13 |=>
        !RDATA_O[3]) else $error("cfg bit 3 set");
    gain_read_a: assert property (RD_I && ADDR_I == 6'h11 |=>
        RDATA_O == $past(CH1_CAL_O.gain_word[23:8])) else $error("gain read");
    rdata_idle_a: assert property (!RD_I |=> RDATA_O == 16'h0000)
        else $error("read data outside read cycle");
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import accr_pkg::*;
;
    logic             CLOCK_I = 1'b0;
    logic             RST_I   = 1'b1;
    logic [5:0]       ADDR_I  = 6'h00;
    logic [15:0]      WDATA_I = 16'h0000;
    logic             WR_I    = 1'b0;
    logic             RD_I    = 1'b0;
    logic [15:0]      RDATA_O;
    accr_cal_type     CH1_CAL_O;
    accr_cal_type     CH2_CAL_O;
    accr_ch2_input_config_type CH2_INPUT_CONFIG_O;
    int               mismatches  = 0;
    int               comparisons = 0;
    logic [15:0]      m[8];

    accr_regs dut_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
        .CH1_CAL_O(CH1_CAL_O), .CH2_CAL_O(CH2_CAL_O), .CH2_INPUT_CONFIG_O(CH2_INPUT_CONFIG_O));

    always #25 CLOCK_I = ~CLOCK_I;

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string n, input logic [47:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    // model: low registers keep only the upper byte
    function automatic logic [15:0] msk(input logic [5:0] a);
        case (a[2:0])
            3'd0, 3'd2, 3'd5, 3'd7: return 16'hff00;
            3'd3:                   return 16'hfff7;
            default:                return 16'hffff;
        endcase
    endfunction

    task automatic rst();
        @(posedge CLOCK_I);
        RST_I <= 1'b1;
        repeat (3) @(posedge CLOCK_I);
        RST_I <= 1'b0;
        m = '{16'h0, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h0};
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge CLOCK_I);
        WR_I <= 1'b1;
        ADDR_I <= a;
        WDATA_I <= d;
        @(posedge CLOCK_I);
        WR_I <= 1'b0;
        if (a inside {[6'h10:6'h17]}) m[a[2:0]] = d & msk(a);
    endtask

    // unmapped places read zero
    task automatic rd(input logic [5:0] a);
        logic [15:0] e;
        e = (a inside {[6'h10:6'h17]}) ? m[a[2:0]] : 16'h0000;
        @(posedge CLOCK_I);
        RD_I <= 1'b1;
        ADDR_I <= a;
        @(posedge CLOCK_I);
        RD_I <= 1'b0;
        #1 cmp("rdata", {32'h0, e}, {32'h0, RDATA_O});
    endtask

    task automatic chk_out();
        #1;
        cmp("ch1", {16'h0, m[0][15:8], m[1], m[2][15:8]}, CH1_CAL_O);
        cmp("ch2", {m[4], m[5][15:8], m[6], m[7][15:8]}, CH2_CAL_O);
        cmp("cfg", {33'h0, m[3][15:6], m[3][1:0], m[3][5], m[3][4],
            m[3][2]}, {33'h0, CH2_INPUT_CONFIG_O});
    endtask

    task automatic sweep();
        for (int a = 14; a < 26; a++) rd(6'(a));
        rd(6'h3f);
        chk_out();
    endtask

    task print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [5:0] a;
        void'($urandom(32'h29e5428a));
        rst();
        sweep();
        repeat (60) begin
            a = 6'h0e + 6'($urandom_range(11));
            wr(a, 16'($urandom));
            chk_out();
            rd(a);
        end
        // every selector code and temperature bit combination
        for (int k = 0; k < 64; k++) begin
            wr(6'h13, {10'($urandom), 6'(k)});
            chk_out();
            rd(6'h13);
        end
        wr(6'h11, 16'hffff);
        wr(6'h12, 16'hffff);
        chk_out();
        rst();
        sweep();
        print_verdict();
    end

    // whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge CLOCK_I);
        mismatches++;
        print_verdict();
    end
endmodule

bind accr_regs accr_regs_props chk_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .CH1_CAL_O(CH1_CAL_O), .CH2_CAL_O(CH2_CAL_O),
    .CH2_INPUT_CONFIG_O(CH2_INPUT_CONFIG_O));
`default_nettype wire

// file: logic/accr_cal_pair.sv
`timescale 1ns/1ns
`default_nettype none

// one high word plus one low byte forming a 24-bit calibration word
module accr_cal_pair
    import accr_pkg::*;
#(
    parameter logic [15:0] HIGH_RST = 16'h0000,
    parameter logic [5:0]  HIGH_OFS = 6'h00,
    parameter logic [5:0]  LOW_OFS  = 6'h01
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register write port
    input  wire logic [5:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    // contents
    output logic      [15:0] high_word,
    output logic      [7:0]  low_byte,
    output logic      [23:0] cal_word
);

    ////////////////////////////////////////////////////////////////////////
    // high word, bits 23 to 8 of the word
    always_ff @(posedge clk) begin
        if (rst) begin
            high_word <= HIGH_RST;
        end else if (wr && addr == HIGH_OFS) begin
            high_word <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            low_byte <= ACCR_ZERO_RST[15:8];
        end else if (wr && addr == LOW_OFS) begin
            low_byte <= wdata[15:ACCR_LOW_BYTE_LSB];
        end
    end

    assign cal_word = {high_word, low_byte};

endmodule

`default_nettype wire

// file: logic/accr_regs.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module accr_regs
    import accr_pkg::*;
(
    // clock and reset
    input  wire logic             CLOCK_I,
    input  wire logic             RST_I,
    // register port
    input  wire logic [5:0]       ADDR_I,
    input  wire logic [15:0]      WDATA_I,
    input  wire logic             WR_I,
    input  wire logic             RD_I,
    output logic      [15:0]      RDATA_O,
    // calibration and configuration toward the datapath
    output accr_cal_type          CH1_CAL_O,
    output accr_cal_type          CH2_CAL_O,
    output accr_ch2_input_config_type      CH2_INPUT_CONFIG_O
);

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] ch1_gain_high_word;
    logic [7:0]  ch1_gain_low_byte;
    logic [23:0] ch1_gain_word;
    logic [15:0] ch2_offset_high_word;
    logic [7:0]  ch2_offset_low_byte;
    logic [23:0] ch2_offset_word;
    logic [15:0] ch2_gain_high_word;
    logic [7:0]  ch2_gain_low_byte;
    logic [23:0] ch2_gain_word;
    logic [7:0]  ch1_offset_low_byte;
    logic [15:0] ch2_input_config;
    logic [15:0] next_rdata;

    ////////////////////////////////////////////////////////////////////////
    // gain resets to unity
    accr_cal_pair #(
        .HIGH_RST (ACCR_GAIN_HIGH_RST),
        .HIGH_OFS (ACCR_CH1_GAIN_HIGH_OFS),
        .LOW_OFS  (ACCR_CH1_GAIN_LOW_OFS)
    ) u_ch1_gain (
        .clk       (CLOCK_I),
        .rst       (RST_I),
        .addr      (ADDR_I),
        .wdata     (WDATA_I),
        .wr        (WR_I),
        .high_word (ch1_gain_high_word),
        .low_byte  (ch1_gain_low_byte),
        .cal_word  (ch1_gain_word)
    );

    accr_cal_pair #(
        .HIGH_RST (ACCR_ZERO_RST),
        .HIGH_OFS (ACCR_CH2_OFS_HIGH_OFS),
        .LOW_OFS  (ACCR_CH2_OFS_LOW_OFS)
    ) u_ch2_offset (
        .clk       (CLOCK_I),
        .rst       (RST_I),
        .addr      (ADDR_I),
        .wdata     (WDATA_I),
        .wr        (WR_I),
        .high_word (ch2_offset_high_word),
        .low_byte  (ch2_offset_low_byte),
        .cal_word  (ch2_offset_word)
    );

    accr_cal_pair #(
        .HIGH_RST (ACCR_GAIN_HIGH_RST),
        .HIGH_OFS (ACCR_CH2_GAIN_HIGH_OFS),
        .LOW_OFS  (ACCR_CH2_GAIN_LOW_OFS)
    ) u_ch2_gain (
        .clk       (CLOCK_I),
        .rst       (RST_I),
        .addr      (ADDR_I),
        .wdata     (WDATA_I),
        .wr        (WR_I),
        .high_word (ch2_gain_high_word),
        .low_byte  (ch2_gain_low_byte),
        .cal_word  (ch2_gain_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // channel 1 offset low byte; its high word lives outside this bank
    // offset low byte
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ch1_offset_low_byte <= ACCR_ZERO_RST[15:8];
        end else if (WR_I && ADDR_I == ACCR_CH1_OCAL_LOW_OFS) begin
            ch1_offset_low_byte <= WDATA_I[15:ACCR_LOW_BYTE_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // config resets zero
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ch2_input_config <= ACCR_ZERO_RST;
        end else if (WR_I && ADDR_I == ACCR_CH2_INPUT_CONFIG_OFS) begin
            ch2_input_config <= WDATA_I & ACCR_CFG_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration fields toward the analog front end and phase logic
    always_comb begin
        CH2_INPUT_CONFIG_O.ch2_phase_delay =
            $signed(ch2_input_config[15:ACCR_PHASE_LSB]);
        CH2_INPUT_CONFIG_O.ch2_input_select =
            accr_input_sel_type'(ch2_input_config[ACCR_MUX_LSB +: 2]);
        CH2_INPUT_CONFIG_O.temp_sensor_source_select =
            ch2_input_config[ACCR_TEMP_SENSOR_SOURCE_SELECT_BIT];
        CH2_INPUT_CONFIG_O.temp_sensor_measure_enable =
            ch2_input_config[ACCR_TEMP_SENSOR_MEASURE_ENABLE_BIT];
        CH2_INPUT_CONFIG_O.temp_sensor_polarity_invert =
            ch2_input_config[ACCR_TS_INV_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // correction words; the high offset word of channel 1 is not held here,
    // so its offset output carries only the low byte
    always_comb begin
        CH1_CAL_O.gain_word   = ch1_gain_word;
        CH2_CAL_O.gain_word   = ch2_gain_word;
        CH2_CAL_O.offset_word = $signed(ch2_offset_word);
        CH1_CAL_O.offset_word = $signed({16'h0000, ch1_offset_low_byte});
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode; unmapped addresses read zero
    always_comb begin
        next_rdata = 16'h0000;
        case (ADDR_I)
            ACCR_CH1_OCAL_LOW_OFS:  next_rdata = {ch1_offset_low_byte, 8'h00};
            ACCR_CH1_GAIN_HIGH_OFS: next_rdata = ch1_gain_high_word;
            ACCR_CH1_GAIN_LOW_OFS:  next_rdata = {ch1_gain_low_byte, 8'h00};
            ACCR_CH2_INPUT_CONFIG_OFS:       next_rdata = ch2_input_config;
            ACCR_CH2_OFS_HIGH_OFS:  next_rdata = ch2_offset_high_word;
            ACCR_CH2_OFS_LOW_OFS:   next_rdata = {ch2_offset_low_byte, 8'h00};
            ACCR_CH2_GAIN_HIGH_OFS: next_rdata = ch2_gain_high_word;
            ACCR_CH2_GAIN_LOW_OFS:  next_rdata = {ch2_gain_low_byte, 8'h00};
            default:                next_rdata = 16'h0000;
        endcase
    end

    // data held only in the cycle after the read strobe
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            RDATA_O <= 16'h0000;
        end else if (RD_I) begin
            RDATA_O <= next_rdata;
        end else begin
            RDATA_O <= 16'h0000;
        end
    end

endmodule

`default_nettype wire
